// *** bstap_pkg.sv ***
package bstap_pkg;
	// ----------------------------------------
	// TAP states (Gray code in the order listed)
	// ----------------------------------------
	typedef enum logic [3:0] {
		BSTAP_TLR = 4'h0,
		BSTAP_RTI = 4'h1,
		BSTAP_SEL_DR = 4'h3,
		BSTAP_CAP_DR = 4'h2,
		BSTAP_SHIFT_DR = 4'h6,
		BSTAP_EXIT1_DR = 4'h7,
		BSTAP_PAUSE_DR = 4'h5,
		BSTAP_EXIT2_DR = 4'h4,
		BSTAP_UPD_DR = 4'hc,
		BSTAP_SEL_IR = 4'hd,
		BSTAP_CAP_IR = 4'hf,
		BSTAP_SHIFT_IR = 4'he,
		BSTAP_EXIT1_IR = 4'ha,
		BSTAP_PAUSE_IR = 4'hb,
		BSTAP_EXIT2_IR = 4'h9,
		BSTAP_UPD_IR = 4'h8
	} bstap_state_t;
	// ----------------------------------------
	// Instructions
	// ----------------------------------------
	localparam int IR_W = 4;
	typedef enum logic [IR_W-1:0] {
		BSTAP_EXTEST = 4'h0,
		BSTAP_SAMPLE = 4'h1,
		BSTAP_IDCODE = 4'h2,
		BSTAP_CLAMP = 4'h3,
		BSTAP_INTEST = 4'h4,
		BSTAP_VPRIV = 4'h8,
		BSTAP_BYPASS = 4'hf
	} bstap_instr_t;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam int ID_W = 32;
	localparam int BSR_N = 8;
	localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5c_3001; // Arbitrary value
endpackage : bstap_pkg

// *** bstap_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Five test pins: mode select, clock, reset, data in, data out.
// RQ2: BYPASS puts one shift stage between data in and data out.
// RQ3: Test reset low forces test-logic-reset at once, asynchronously.
// RQ4: Test-logic-reset loads IDCODE into the instruction register.
// RQ5: Controller stays in reset during normal operation; tester keeps it there.
// RQ6: IDCODE selects the identification register as data path.
// RQ7: Capture-DR loads the fixed code, then shifts toward data out.
// RQ8: Identification register is 32 bits: maker, part, version.
// RQ9: Bit 31 nearest data in, bit 0 shifted out first.
// RQ10: EXTEST drives and observes pins from the scan register.
// RQ11: SAMPLE captures pins in normal mode and preloads output latches.
// RQ12: CLAMP selects bypass while pins are driven from the scan register.
// RQ13: INTEST drives the core from the chain and captures its responses.
// RQ14: A private vendor test instruction is decoded.
// RQ15: Sixteen-state sequence on rising clock, TDO on falling, floats elsewhere.
// RQ16: Four-bit opcodes; all ones and unused codes act as BYPASS.
module bstap_top
	import bstap_pkg::*;
#(
	parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEF // Arbitrary value
) (
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic TCK_IN, // RQ1
	input wire logic TMS_IN,
	input wire logic TDI_IN,
	input wire logic TRST_N_IN,
	output logic TDO_OUT,
	output logic TDO_OE_OUT,
	input wire logic [BSR_N-1:0] PIN_IN,
	input wire logic [BSR_N-1:0] CORE_OUT_IN,
	output logic [BSR_N-1:0] PIN_OUT,
	output logic [BSR_N-1:0] CORE_IN_OUT,
	output logic VPRIV_TEST_OUT
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [BSR_N-1:0] pin_s1_q;
	logic [BSR_N-1:0] pin_s2_q;
	logic tck_d1_q;
	logic [1:0] trst_sync_q;
	logic trst_arst;
	logic trst_n;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_rise;
	logic tck_fall;
	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			tck_d1_q <= 1'b0;
		end else begin
			s1_q <= {TDI_IN, TMS_IN, TCK_IN};
			s2_q <= s1_q;
			pin_s1_q <= PIN_IN;
			pin_s2_q <= pin_s1_q;
			tck_d1_q <= s2_q[0];
		end
	end
	assign tck_s = s2_q[0];
	assign tms_s = s2_q[1];
	assign tdi_s = s2_q[2];
	// Edges found on the system clock; TCK must stay well below it
	assign tck_rise = tck_s & ~tck_d1_q;
	assign tck_fall = ~tck_s & tck_d1_q;
	// ----------------------------------------
	// Test reset: asserts at once, releases after two clocks
	// ----------------------------------------
	assign trst_arst = SYS_RST_IN | ~TRST_N_IN; // RQ3
	always_ff @(posedge CLOCK_IN or posedge trst_arst) begin
		if (trst_arst) begin
			trst_sync_q <= 2'h0;
		end else begin
			trst_sync_q <= {trst_sync_q[0], 1'b1};
		end
	end
	// Synchronised release lets all TAP flops leave reset together
	assign trst_n = trst_sync_q[1];
	logic arst;
	assign arst = SYS_RST_IN | ~trst_n; // RQ3 RQ5
	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	bstap_state_t st_q;
	bstap_state_t st_d;
	function automatic bstap_state_t next_st(input bstap_state_t s, input logic m);
		case (s)
			BSTAP_TLR: next_st = m ? BSTAP_TLR : BSTAP_RTI;
			BSTAP_RTI: next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_DR: next_st = m ? BSTAP_SEL_IR : BSTAP_CAP_DR;
			BSTAP_CAP_DR: next_st = m ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
			BSTAP_SHIFT_DR: next_st = m ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
			BSTAP_EXIT1_DR: next_st = m ? BSTAP_UPD_DR : BSTAP_PAUSE_DR;
			BSTAP_PAUSE_DR: next_st = m ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
			BSTAP_EXIT2_DR: next_st = m ? BSTAP_UPD_DR : BSTAP_SHIFT_DR;
			BSTAP_UPD_DR: next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			BSTAP_SEL_IR: next_st = m ? BSTAP_TLR : BSTAP_CAP_IR;
			BSTAP_CAP_IR: next_st = m ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
			BSTAP_SHIFT_IR: next_st = m ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
			BSTAP_EXIT1_IR: next_st = m ? BSTAP_UPD_IR : BSTAP_PAUSE_IR;
			BSTAP_PAUSE_IR: next_st = m ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
			BSTAP_EXIT2_IR: next_st = m ? BSTAP_UPD_IR : BSTAP_SHIFT_IR;
			BSTAP_UPD_IR: next_st = m ? BSTAP_SEL_DR : BSTAP_RTI;
			default: next_st = BSTAP_TLR;
		endcase
	endfunction : next_st
	assign st_d = next_st(st_q, tms_s);
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			st_q <= BSTAP_TLR; // RQ3
		end else if (tck_rise) begin
			st_q <= st_d; // RQ15
		end
	end
	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	logic [IR_W-1:0] ir_sh_q;
	bstap_instr_t ir_q;
	// Unused codes fall back to BYPASS so the chain stays one bit
	function automatic bstap_instr_t decode_ir(input logic [IR_W-1:0] c);
		case (c)
			BSTAP_EXTEST, BSTAP_SAMPLE, BSTAP_IDCODE, BSTAP_CLAMP,
			BSTAP_INTEST, BSTAP_VPRIV: decode_ir = bstap_instr_t'(c);
			default: decode_ir = BSTAP_BYPASS; // RQ16
		endcase
	endfunction : decode_ir
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			ir_sh_q <= IR_CAPTURE;
			ir_q <= BSTAP_IDCODE;
		end else if (tck_rise) begin
			if (st_q == BSTAP_TLR) begin
				ir_q <= BSTAP_IDCODE; // RQ4
			end else if (st_q == BSTAP_CAP_IR) begin
				ir_sh_q <= IR_CAPTURE;
			end else if (st_q == BSTAP_SHIFT_IR) begin
				ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
			end else if (st_q == BSTAP_UPD_IR) begin
				ir_q <= decode_ir(ir_sh_q); // RQ14 RQ16
			end
		end
	end
	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	logic byp_q;
	logic [ID_W-1:0] id_q;
	logic [BSR_N*2-1:0] bsr_q;
	logic [BSR_N*2-1:0] bsr_upd_q;
	logic sel_bsr;
	logic sel_id;
	logic drv_pins;
	assign sel_id = (ir_q == BSTAP_IDCODE); // RQ6
	assign sel_bsr = (ir_q == BSTAP_EXTEST) | (ir_q == BSTAP_SAMPLE) | (ir_q == BSTAP_INTEST);
	assign drv_pins = (ir_q == BSTAP_EXTEST) | (ir_q == BSTAP_CLAMP); // RQ10 RQ12
	// Bypass stage also serves CLAMP, the private code and unused codes
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			byp_q <= 1'b0;
		end else if (tck_rise && !sel_id && !sel_bsr) begin
			if (st_q == BSTAP_CAP_DR) begin
				byp_q <= 1'b0;
			end else if (st_q == BSTAP_SHIFT_DR) begin
				byp_q <= tdi_s; // RQ2
			end
		end
	end
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			id_q <= '0;
		end else if (tck_rise && sel_id) begin
			if (st_q == BSTAP_CAP_DR) begin
				id_q <= ID_CODE; // RQ7 RQ8
			end else if (st_q == BSTAP_SHIFT_DR) begin
				id_q <= {tdi_s, id_q[ID_W-1:1]}; // RQ9
			end
		end
	end
	// Cells: low half observe pins, high half observe core outputs
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			bsr_q <= '0;
			bsr_upd_q <= '0;
		end else if (tck_rise && sel_bsr) begin
			if (st_q == BSTAP_CAP_DR) begin
				// Pin values come through the synchroniser
				bsr_q <= {CORE_OUT_IN, pin_s2_q}; // RQ11 RQ13
			end else if (st_q == BSTAP_SHIFT_DR) begin
				bsr_q <= {tdi_s, bsr_q[BSR_N*2-1:1]};
			end else if (st_q == BSTAP_UPD_DR) begin
				bsr_upd_q <= bsr_q; // RQ11
			end
		end
	end
	// ----------------------------------------
	// Pin and core muxing
	// ----------------------------------------
	// Functional paths stay combinational so normal operation sees no delay
	always_comb begin
		PIN_OUT = drv_pins ? bsr_upd_q[BSR_N*2-1:BSR_N] : CORE_OUT_IN; // RQ10 RQ12
		CORE_IN_OUT = (ir_q == BSTAP_INTEST) ? bsr_upd_q[BSR_N-1:0] : PIN_IN; // RQ13
	end
	assign VPRIV_TEST_OUT = (ir_q == BSTAP_VPRIV); // RQ14
	// ----------------------------------------
	// Serial output, falling TCK
	// ----------------------------------------
	logic tdo_q;
	logic tdo_oe_q;
	logic dr_bit;
	assign dr_bit = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
	// Falling-edge update gives the tester half a period of hold
	always_ff @(posedge CLOCK_IN or posedge arst) begin
		if (arst) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_q <= (st_q == BSTAP_SHIFT_DR) | (st_q == BSTAP_SHIFT_IR); // RQ15
			tdo_q <= (st_q == BSTAP_SHIFT_IR) ? ir_sh_q[0] : dr_bit; // RQ15
		end
	end
	assign TDO_OUT = tdo_q;
	assign TDO_OE_OUT = tdo_oe_q;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Checks run on the system clock; all but AST_TRST_RESET and COV_TRST_MID stand down in reset
	AST_TRST_RESET: assert property (@(posedge CLOCK_IN) !TRST_N_IN |=> st_q == BSTAP_TLR) // RQ3
		else $error("TAP not in reset under test reset");
	AST_TLR_IR: assert property (@(posedge CLOCK_IN) disable iff (arst)
		st_q == BSTAP_TLR && tck_rise |=> ir_q == BSTAP_IDCODE) // RQ4
		else $error("Reset state did not load IDCODE");
	AST_TMS_FIVE: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && tms_s && st_q == BSTAP_SEL_IR |=> st_q == BSTAP_TLR) // RQ15
		else $error("Select-IR with TMS high missed reset");
	AST_ID_CAP: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && sel_id && st_q == BSTAP_CAP_DR |=> id_q == ID_CODE) // RQ7
		else $error("ID code not captured");
	AST_BYP_SHIFT: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && ir_q == BSTAP_BYPASS && st_q == BSTAP_SHIFT_DR |=> byp_q == $past(tdi_s)) // RQ2
		else $error("Bypass stage did not take data in");
	AST_ID_LSB: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_fall && sel_id && st_q == BSTAP_SHIFT_DR |=> TDO_OUT == $past(id_q[0])) // RQ9
		else $error("ID bit 0 not first on data out");
	AST_OE_SHIFT: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_fall |=> TDO_OE_OUT == $past(st_q == BSTAP_SHIFT_DR || st_q == BSTAP_SHIFT_IR)) // RQ15
		else $error("Data out enable wrong after falling test clock");
	AST_TDO_HOLD: assert property (@(posedge CLOCK_IN) disable iff (arst)
		!tck_fall |=> $stable(TDO_OUT) && $stable(TDO_OE_OUT)) // RQ15
		else $error("Data out changed away from falling test clock");
	AST_IR_TDO: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_fall && st_q == BSTAP_SHIFT_IR |=> TDO_OUT == $past(ir_sh_q[0]) && TDO_OE_OUT) // RQ15
		else $error("Instruction bit not on data out");
	AST_STATE_HOLD: assert property (@(posedge CLOCK_IN) disable iff (arst)
		!tck_rise |=> $stable(st_q)) // RQ15
		else $error("TAP state moved without rising test clock");
	AST_IR_HOLD: assert property (@(posedge CLOCK_IN) disable iff (arst)
		!(tck_rise && (st_q == BSTAP_UPD_IR || st_q == BSTAP_TLR)) |=> $stable(ir_q)) // RQ4
		else $error("Instruction changed outside update or reset");
	AST_IR_ONES: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && st_q == BSTAP_UPD_IR && (&ir_sh_q) |=> ir_q == BSTAP_BYPASS) // RQ16
		else $error("All-ones code did not select BYPASS");
	AST_BYP_CAP: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && ir_q == BSTAP_BYPASS && st_q == BSTAP_CAP_DR |=> !byp_q) // RQ2
		else $error("Bypass stage not cleared at capture");
	AST_BSR_UPD: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && sel_bsr && st_q == BSTAP_UPD_DR |=> bsr_upd_q == $past(bsr_q)) // RQ11
		else $error("Scan latches not loaded at update");
	AST_EXTEST_PINS: assert property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_EXTEST |-> PIN_OUT == bsr_upd_q[BSR_N*2-1:BSR_N]) // RQ10
		else $error("EXTEST pins not from scan latches");
	AST_CLAMP_PINS: assert property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_CLAMP |-> PIN_OUT == bsr_upd_q[BSR_N*2-1:BSR_N] && !sel_bsr) // RQ12
		else $error("CLAMP path wrong");
	AST_INTEST_CORE: assert property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_INTEST |-> CORE_IN_OUT == bsr_upd_q[BSR_N-1:0]) // RQ13
		else $error("INTEST core stimulus wrong");
	AST_SAMPLE_FUNC: assert property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_SAMPLE |-> PIN_OUT == CORE_OUT_IN) // RQ11
		else $error("SAMPLE disturbed pins");
	AST_PRIV: assert property (@(posedge CLOCK_IN) disable iff (arst)
		tck_rise && st_q == BSTAP_UPD_IR && ir_sh_q == BSTAP_VPRIV |=> VPRIV_TEST_OUT) // RQ14
		else $error("Private test flag wrong");
	COV_IDCODE: cover property (@(posedge CLOCK_IN) disable iff (arst)
		sel_id && st_q == BSTAP_SHIFT_DR && tck_rise);
	COV_EXTEST: cover property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_EXTEST && st_q == BSTAP_UPD_DR);
	COV_IR_UPD: cover property (@(posedge CLOCK_IN) disable iff (arst)
		st_q == BSTAP_UPD_IR && tck_rise);
	COV_BYPASS: cover property (@(posedge CLOCK_IN) disable iff (arst)
		ir_q == BSTAP_BYPASS && st_q == BSTAP_SHIFT_DR && tck_rise);
	COV_TRST_MID: cover property (@(posedge CLOCK_IN)
		st_q == BSTAP_SHIFT_DR ##1 arst);
endmodule : bstap_top

// *** bstap_jtag_host.sv ***
`timescale 1ns/1ps
module bstap_jtag_host (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_in
);
	logic last_q;
	// ----
	// Test clock parked low, test reset held from power-up
	// ----
	initial begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h0;
		trst_n_out = 1'h0;
		last_q = 1'h0;
	end
	task automatic set_trst(input logic v);
		trst_n_out = v;
	endtask : set_trst
	// One 80 ns clock; a floating output reads inverted
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#40;
		tdo = tdo_oe_in ? tdo_in : ~last_q;
		last_q = tdo;
		tck_out = 1'h1;
		#40;
		tck_out = 1'h0;
	endtask : tick
	// Idle to shift, n bits, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic b;
		dout = '0;
		tick(1'h1, 1'h0, b);
		if (ir)
			tick(1'h1, 1'h0, b);
		tick(1'h0, 1'h0, b);
		tick(1'h0, 1'h0, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'h1, 1'h0, b);
		tick(1'h0, 1'h0, b);
	endtask : scan
	task automatic reset5();
		logic b;
		repeat (5)
			tick(1'h1, 1'h0, b);
		tick(1'h0, 1'h0, b);
	endtask : reset5
endmodule : bstap_jtag_host

// *** tb_bstap_top.sv ***
`timescale 1ns/1ps
module tb_bstap_top;
	import bstap_pkg::*;
	typedef struct packed {
		logic [3:0] op;
		logic [5:0] len;
		logic chain;
		logic cap;
		logic pin_sel;
		logic core_sel;
		logic vpriv;
	} bstap_row_t;
	localparam logic [ID_W-1:0] TB_ID = 32'h1357_9bdf; // Arbitrary value
	localparam bstap_row_t ROWS [9] = '{
		'{4'h1, 6'h10, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
		'{4'h0, 6'h10, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0},
		'{4'h3, 6'h01, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0},
		'{4'h4, 6'h10, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0},
		'{4'h2, 6'h20, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
		'{4'hf, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
		'{4'h5, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
		'{4'ha, 6'h01, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
		'{4'h8, 6'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1}
	};
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, vpriv;
	logic [7:0] pin_v = 8'h00;
	logic [7:0] core_v = 8'h00;
	logic [7:0] pin_o, core_o;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	bstap_top #(.ID_CODE(TB_ID)) i_bstap_top (
		.CLOCK_IN(clk), .SYS_RST_IN(rst), .TCK_IN(tck), .TMS_IN(tms),
		.TDI_IN(tdi), .TRST_N_IN(trst_n), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
		.PIN_IN(pin_v), .CORE_OUT_IN(core_v), .PIN_OUT(pin_o),
		.CORE_IN_OUT(core_o), .VPRIV_TEST_OUT(vpriv)
	);
	bstap_jtag_host i_bstap_jtag_host (
		.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
		.tdo_in(tdo), .tdo_oe_in(tdo_oe)
	);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic pins(input logic ps, input logic cs, input logic [15:0] lat);
		chk("pin_out", ps ? lat[15:8] : core_v, pin_o);
		chk("core_in_out", cs ? lat[7:0] : pin_v, core_o);
	endtask : pins
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		logic [63:0] o;
		logic [15:0] lat;
		logic [15:0] p;
		logic b;
		bstap_row_t r;
		lat = 16'h0000;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		i_bstap_jtag_host.set_trst(1'h1);
		repeat (4) @(negedge clk);
		pins(1'h0, 1'h0, lat);
		chk("tdo_oe", 1'h0, tdo_oe);
		i_bstap_jtag_host.reset5();
		i_bstap_jtag_host.scan(1'h0, 48, 64'h1, o);
		chk("idcode", TB_ID, o[31:0]);
		chk("id_len", 32'h1, o[63:32]);
		for (int i = 0; i < 9; i++) begin
			r = ROWS[i];
			p = 16'h5ac3 ^ {4{i[3:0]}};
			@(negedge clk);
			pin_v = 8'h3c + i[7:0];
			core_v = 8'hc5 - i[7:0];
			i_bstap_jtag_host.scan(1'h1, 4, {60'h0, r.op}, o);
			chk("ir_capture", {28'h0, IR_CAPTURE}, o[31:0]);
			chk("vpriv", r.vpriv, vpriv);
			pins(r.pin_sel, r.core_sel, lat);
			if (r.len != 6'h00) begin
				i_bstap_jtag_host.scan(1'h0, 48, {16'h0, p, 31'h0, 1'h1}, o);
				if (r.chain)
					lat = p;
				pins(r.pin_sel, r.core_sel, lat);
				chk("dr_len", 32'h1, 32'(o >> r.len));
				if (r.cap)
					chk("capture", {core_v, pin_v}, o[15:0]);
			end
		end
		// Test reset dropped in mid shift with the test clock still
		i_bstap_jtag_host.scan(1'h1, 4, 64'h0, o);
		i_bstap_jtag_host.tick(1'h1, 1'h0, b);
		i_bstap_jtag_host.tick(1'h0, 1'h0, b);
		i_bstap_jtag_host.tick(1'h0, 1'h0, b);
		i_bstap_jtag_host.tick(1'h0, 1'h1, b);
		repeat (5) @(negedge clk);
		chk("tdo_oe", 1'h1, tdo_oe);
		i_bstap_jtag_host.set_trst(1'h0);
		#1;
		chk("tdo_oe", 1'h0, tdo_oe);
		pins(1'h0, 1'h0, lat);
		@(negedge clk);
		i_bstap_jtag_host.set_trst(1'h1);
		repeat (4) @(negedge clk);
		i_bstap_jtag_host.reset5();
		i_bstap_jtag_host.scan(1'h0, 48, 64'h1, o);
		chk("idcode", TB_ID, o[31:0]);
		// Five mode-select highs return to reset
		i_bstap_jtag_host.scan(1'h1, 4, 64'hf, o);
		i_bstap_jtag_host.reset5();
		i_bstap_jtag_host.scan(1'h0, 48, 64'h1, o);
		chk("idcode", TB_ID, o[31:0]);
		stop_test();
	end
endmodule : tb_bstap_top
